// ===== mcs_top.sv
// Purpose: Configuration, status, boot mode and watchdog reaction
// Assumes: Protocol engine and NV store on clk; recovery switch is a pin
// Notes:   Register port uses the host reference numbers as addresses
`timescale 1ns/1ps
`default_nettype none
module mcs_top
  import mcs_pkg::*;
#(
  parameter int unsigned MWDT_LIMIT = MWDT_CYCLES
)(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Register access from the protocol engine
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic                    reg_rvalid,
  output logic [15:0]             reg_rdata,
  output logic                    reg_err,
  // Command activity
  input  wire logic               cmd_received,
  input  wire logic               resp_sent,
  output logic                    led_on,
  // Recovery switch pin
  input  wire logic               recovery_sw,
  // Stored configuration
  input  wire logic [7:0]         nv_addr,
  input  wire logic [5:0]         nv_baud,
  input  wire logic               nv_cksum,
  input  wire logic               nv_proto,
  // Effective link settings
  output logic                    recovery_mode,
  output logic [7:0]              eff_addr,
  output logic [5:0]              eff_baud,
  output logic                    eff_cksum,
  output logic                    eff_proto,
  // Stored configuration report
  output logic [7:0]              rpt_addr,
  output logic [5:0]              rpt_baud,
  output logic                    rpt_cksum,
  output logic                    rpt_proto,
  // Setting change requests
  input  wire logic               cfg_chg_req,
  input  wire logic               proto_chg_req,
  output logic                    chg_ack,
  output logic                    chg_grant,
  // Watchdogs
  input  wire logic               mod_kick,
  output logic                    mod_reset_req,
  input  wire logic               hwdt_expire,
  output logic                    safe_state,
  // Conversion and scaling
  output logic                    fast_mode,
  input  wire logic               smp_valid,
  input  wire logic [2:0]         smp_chan,
  input  wire logic [15:0]        smp_pos,
  input  wire logic               smp_under,
  output logic                    eng_valid,
  output logic signed [15:0]      eng_value
);
  // ****************************************************************
  // Register decode
  // ****************************************************************
  function automatic logic is_type(input logic [15:0] a);
    return a >= ADDR_TYPE_BASE && a <= ADDR_TYPE_LAST;
  endfunction : is_type

  logic [7:0]  type_code [8];
  logic        first_read;
  logic        hwdt_status;
  logic [15:0] hwdt_count;
  logic [2:0]  tidx;
  logic [15:0] next_rdata;
  logic        next_err;

  assign tidx = reg_addr[2:0] - ADDR_TYPE_BASE[2:0];

  always_comb begin
    next_rdata = 16'h0000;
    next_err = 1'b0;
    if (reg_addr == ADDR_FAST_MODE) begin
      next_rdata = {15'h0000, fast_mode};
    end else if (reg_addr == ADDR_FIRST_READ) begin
      next_rdata = {15'h0000, first_read};
    end else if (reg_addr == ADDR_HWDT_STATUS) begin
      next_rdata = {15'h0000, hwdt_status};
    end else if (reg_addr == ADDR_HWDT_COUNT) begin
      next_rdata = hwdt_count;
    end else if (is_type(reg_addr)) begin
      next_rdata = {8'h00, type_code[tidx]};
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= 16'h0000;
      reg_err    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_err    <= (reg_rd || reg_wr) && next_err;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_mode <= RST_FAST_MODE;
    end else if (reg_wr && reg_addr == ADDR_FAST_MODE) begin
      fast_mode <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_read <= RST_FIRST_READ;
    end else if (reg_rd && reg_addr == ADDR_FIRST_READ) begin
      first_read <= 1'b0;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_type
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        type_code[g] <= RST_TYPE_CODE;
      end else if (reg_wr && is_type(reg_addr) && tidx == 3'(g)) begin
        type_code[g] <= reg_wdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Host watchdog reaction
  // ****************************************************************
  // Expiry beats a clear in the same cycle so no timeout is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hwdt_status <= 1'b0;
    end else if (hwdt_expire) begin
      hwdt_status <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_HWDT_STATUS && reg_wdata[0]) begin
      hwdt_status <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hwdt_count <= RST_HWDT_COUNT;
    end else if (reg_wr && reg_addr == ADDR_HWDT_COUNT &&
                 reg_wdata == 16'h0000) begin
      hwdt_count <= {15'h0000, hwdt_expire};
    end else if (hwdt_expire && hwdt_count != 16'hffff) begin
      hwdt_count <= hwdt_count + 16'h0001;
    end
  end

  // Safe state holds until software acknowledges the timeout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      safe_state <= 1'b0;
    end else if (hwdt_expire) begin
      safe_state <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_HWDT_STATUS && reg_wdata[0]) begin
      safe_state <= 1'b0;
    end
  end

  // ****************************************************************
  // Module watchdog
  // ****************************************************************
  logic [31:0] mwdt_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mwdt_cnt      <= 32'h0000_0000;
      mod_reset_req <= 1'b0;
    end else if (mod_kick) begin
      mwdt_cnt      <= 32'h0000_0000;
      mod_reset_req <= 1'b0;
    end else if (mwdt_cnt >= MWDT_LIMIT - 1) begin
      mwdt_cnt      <= 32'h0000_0000;
      mod_reset_req <= 1'b1;
    end else begin
      mwdt_cnt      <= mwdt_cnt + 32'h0000_0001;
      mod_reset_req <= 1'b0;
    end
  end

  // ****************************************************************
  // Activity indicator
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_on <= RST_LED_ON;
    end else if (cmd_received) begin
      led_on <= 1'b0;
    end else if (resp_sent) begin
      led_on <= 1'b1;
    end
  end

  // ****************************************************************
  // Recovery boot mode
  // ****************************************************************
  // Switch is sampled once after reset; moving it later has no effect
  logic      sw_meta;
  logic      sw_sync;
  logic [1:0] settle;
  mcs_boot_t boot_st;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= recovery_sw;
      sw_sync <= sw_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_st       <= MCS_BOOT;
      settle        <= 2'b00;
      recovery_mode <= 1'b0;
    end else begin
      case (boot_st)
        MCS_BOOT: begin
          settle <= settle + 2'b01;
          if (settle == 2'(STRAP_SETTLE)) begin
            recovery_mode <= sw_sync;
            boot_st       <= MCS_RUN;
          end
        end
        MCS_RUN: begin
          boot_st <= MCS_RUN;
        end
        default: begin
          boot_st <= MCS_BOOT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_addr  <= REC_ADDR;
      eff_baud  <= REC_BAUD_9600;
      eff_cksum <= REC_CKSUM;
      eff_proto <= PROTO_ASCII;
    end else if (recovery_mode) begin
      eff_addr  <= REC_ADDR;
      eff_baud  <= REC_BAUD_9600;
      eff_cksum <= REC_CKSUM;
      eff_proto <= PROTO_ASCII;
    end else begin
      eff_addr  <= nv_addr;
      eff_baud  <= nv_baud;
      eff_cksum <= nv_cksum;
      eff_proto <= nv_proto;
    end
  end

  // Report always shows the stored copy, override or not
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rpt_addr  <= 8'h00;
      rpt_baud  <= 6'h00;
      rpt_cksum <= 1'b0;
      rpt_proto <= 1'b0;
    end else begin
      rpt_addr  <= nv_addr;
      rpt_baud  <= nv_baud;
      rpt_cksum <= nv_cksum;
      rpt_proto <= nv_proto;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_ack   <= 1'b0;
      chg_grant <= 1'b0;
    end else begin
      chg_ack   <= cfg_chg_req || proto_chg_req;
      chg_grant <= (cfg_chg_req || proto_chg_req) && recovery_mode;
    end
  end

  // ****************************************************************
  // Engineering scaling
  // ****************************************************************
  mcs_scaler u_scaler (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (smp_valid),
    .in_type   (type_code[smp_chan]),
    .in_pos    (smp_pos),
    .in_under  (smp_under),
    .out_valid (eng_valid),
    .out_value (eng_value)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_fast_write: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && reg_addr == ADDR_FAST_MODE
    |=> fast_mode == $past(reg_wdata[0]))
    else $error("fast mode write not stored");
  a_first_once: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_FIRST_READ
    ##[1:4] reg_rd && reg_addr == ADDR_FIRST_READ
    |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("second status read not zero");
  a_led_cmd: assert property (@(posedge clk)
    disable iff (!rst_b)
    cmd_received |=> !led_on)
    else $error("indicator on after command");
  a_led_resp: assert property (@(posedge clk)
    disable iff (!rst_b)
    resp_sent && !cmd_received |=> led_on)
    else $error("indicator off after response");
  a_rec_settings: assert property (@(posedge clk)
    disable iff (!rst_b)
    $past(recovery_mode) |-> eff_addr == 8'h00 && eff_baud == 6'h06
                             && !eff_cksum && !eff_proto)
    else $error("recovery settings not forced");
  // Gated on reset so the first edge after release sees no stale copy
  a_rec_report: assert property (@(posedge clk)
    disable iff (!rst_b)
    rst_b |=> rpt_baud == $past(nv_baud) && rpt_addr == $past(nv_addr))
    else $error("report differs from stored copy");
  a_grant_mode: assert property (@(posedge clk)
    disable iff (!rst_b)
    (cfg_chg_req || proto_chg_req)
    |=> chg_ack && chg_grant == $past(recovery_mode))
    else $error("change granted outside recovery");
  a_boot_latch: assert property (@(posedge clk)
    disable iff (!rst_b)
    $rose(boot_st == MCS_RUN) |-> recovery_mode == $past(sw_sync))
    else $error("boot mode not from switch");
  a_type_rw: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && is_type(reg_addr) ##1 !reg_wr ##1 reg_rd && !reg_wr
    && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3))
    else $error("type code read back wrong");
  a_mwdt_fire: assert property (@(posedge clk)
    disable iff (!rst_b)
    mod_reset_req |-> !$past(mod_kick))
    else $error("module reset despite kick");
  a_safe_exp: assert property (@(posedge clk)
    disable iff (!rst_b)
    hwdt_expire |=> safe_state && hwdt_status)
    else $error("safe state not entered");
  a_status_clr: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && reg_addr == ADDR_HWDT_STATUS && reg_wdata[0] && !hwdt_expire
    |=> !hwdt_status)
    else $error("timeout status not cleared");
  a_count_inc: assert property (@(posedge clk)
    disable iff (!rst_b)
    hwdt_expire && !reg_wr && hwdt_count < 16'hffff
    |=> hwdt_count == $past(hwdt_count) + 16'h0001)
    else $error("timeout count not incremented");
  a_normal_cfg: assert property (@(posedge clk)
    disable iff (!rst_b)
    boot_st == MCS_RUN && !recovery_mode |=> eff_addr == $past(nv_addr)
    && eff_proto == $past(nv_proto))
    else $error("stored settings not used");

  c_recovery: cover property (@(posedge clk) disable iff (!rst_b)
    recovery_mode && cfg_chg_req);
  c_timeout: cover property (@(posedge clk) disable iff (!rst_b)
    hwdt_expire ##[1:20] reg_wr && reg_addr == ADDR_HWDT_STATUS);
  c_cmd_resp: cover property (@(posedge clk) disable iff (!rst_b)
    cmd_received ##[1:50] resp_sent);
  c_under: cover property (@(posedge clk) disable iff (!rst_b)
    smp_valid && smp_under);
endmodule : mcs_top
`default_nettype wire

// ===== mcs_pkg.sv
// Purpose: Shared constants for the module configuration and status block
// Assumes: 25 MHz module clock, register references as host-visible numbers
// Notes:   Addresses are the decimal reference numbers the host uses
`default_nettype none
package mcs_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned MWDT_TIME_MS  = 100;
  localparam int unsigned MWDT_CYCLES   = MWDT_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned STRAP_SETTLE  = 3;

  // ****************************************************************
  // Register references
  // ****************************************************************
  localparam logic [15:0] ADDR_HWDT_STATUS = 16'h010e;  // 270
  localparam logic [15:0] ADDR_FAST_MODE   = 16'h010f;  // 271
  localparam logic [15:0] ADDR_FIRST_READ  = 16'h0111;  // 273
  localparam logic [15:0] ADDR_TYPE_BASE   = 16'h9d41;  // 40257
  localparam logic [15:0] ADDR_TYPE_LAST   = 16'h9d48;  // 40264
  localparam logic [15:0] ADDR_HWDT_COUNT  = 16'h9e2c;  // 40492

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        RST_FAST_MODE   = 1'b0;
  localparam logic        RST_FIRST_READ  = 1'b1;
  localparam logic [7:0]  RST_TYPE_CODE   = 8'h08;
  localparam logic [15:0] RST_HWDT_COUNT  = 16'h0000;
  localparam logic        RST_LED_ON      = 1'b1;

  // ****************************************************************
  // Recovery defaults and encodings
  // ****************************************************************
  localparam logic [7:0]  REC_ADDR        = 8'h00;
  localparam logic [5:0]  REC_BAUD_9600   = 6'h06;
  localparam logic        REC_CKSUM       = 1'b0;
  localparam logic        PROTO_ASCII     = 1'b0;
  localparam logic        PROTO_MODBUS    = 1'b1;

  // ****************************************************************
  // Input type codes and engineering limits
  // ****************************************************************
  localparam logic [7:0]  TC_4_20MA       = 8'h07;
  localparam logic [7:0]  TC_PM10V        = 8'h08;
  localparam logic [7:0]  TC_PM5V         = 8'h09;
  localparam logic [7:0]  TC_PM1V         = 8'h0a;
  localparam logic [7:0]  TC_PM500MV      = 8'h0b;
  localparam logic [7:0]  TC_PM150MV      = 8'h0c;
  localparam logic [7:0]  TC_PM20MA       = 8'h0d;
  localparam logic [7:0]  TC_0_20MA       = 8'h1a;
  localparam logic [7:0]  TC_4_20MA_B     = 8'h1d;
  localparam logic signed [15:0] UNDER_NEG = 16'sh8000;  // -32768
  localparam logic signed [15:0] UNDER_ZERO = 16'sh0000;

  typedef enum logic [1:0] {
    MCS_BOOT = 2'b01,
    MCS_RUN  = 2'b10
  } mcs_boot_t;
endpackage : mcs_pkg
`default_nettype wire

// ===== mcs_scaler.sv
// Purpose: Engineering-unit scaling of one conversion result
// Assumes: pos is full-scale position 0..65535 from min to max
// Notes:   One cycle from in_valid to out_valid
`timescale 1ns/1ps
`default_nettype none
module mcs_scaler
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Sample in
  input  wire logic               in_valid,
  input  wire logic [7:0]         in_type,
  input  wire logic [15:0]        in_pos,
  input  wire logic               in_under,
  // Result out
  output logic                    out_valid,
  output logic signed [15:0]      out_value
);
  function automatic logic signed [16:0] lim(input logic [7:0] tc,
                                             input logic hi);
    logic signed [16:0] v;
    v = 17'sd0;
    case (tc)
      TC_4_20MA, TC_4_20MA_B: v = hi ? 17'sd20000 : 17'sd4000;
      TC_PM10V, TC_PM1V:      v = hi ? 17'sd10000 : -17'sd10000;
      TC_PM5V, TC_PM500MV:    v = hi ? 17'sd5000  : -17'sd5000;
      TC_PM150MV:             v = hi ? 17'sd15000 : -17'sd15000;
      TC_PM20MA:              v = hi ? 17'sd20000 : -17'sd20000;
      TC_0_20MA:              v = hi ? 17'sd20000 : 17'sd0;
      default:                v = 17'sd0;
    endcase
    return v;
  endfunction : lim

  logic signed [16:0] lo_v;
  logic signed [16:0] span;
  logic signed [34:0] prod;
  logic signed [15:0] next_value;

  always_comb begin
    lo_v = lim(in_type, 1'b0);
    span = lim(in_type, 1'b1) - lo_v;
    prod = span * $signed({1'b0, in_pos});
    next_value = 16'(lo_v + 17'(prod >>> 16));
    if (in_under) begin
      if (in_type == TC_4_20MA || in_type == TC_0_20MA) begin
        next_value = UNDER_NEG;
      end else if (in_type == TC_4_20MA_B) begin
        next_value = UNDER_ZERO;
      end else begin
        next_value = 16'(lo_v);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_value <= 16'sh0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_value <= next_value;
      end
    end
  end

  a_under_neg: assert property (@(posedge clk)
    disable iff (!rst_b)
    in_valid && in_under && in_type == TC_0_20MA
    |=> out_valid && out_value == UNDER_NEG)
    else $error("under range on 0-20 mA not -32768");
  a_scale_ends: assert property (@(posedge clk)
    disable iff (!rst_b)
    in_valid && !in_under && in_type == TC_4_20MA && in_pos == 16'h0000
    |=> out_value == 16'sd4000)
    else $error("4-20 mA bottom not 4000");
endmodule : mcs_scaler
`default_nettype wire

// ===== mcs_host_model.sv
// Purpose: Host side of the serial link, seen as command activity
// Assumes: One command at a time, reply after a chosen turnaround
// Notes:   Gap sets a prompt or a slow reply
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model
  import mcs_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Command activity
  output logic      cmd_received,
  output logic      resp_sent
);
  initial begin
    cmd_received = 1'b0;
    resp_sent    = 1'b0;
  end
  task automatic transact(input int gap);
    @(posedge clk);
    cmd_received <= 1'b1;
    @(posedge clk);
    cmd_received <= 1'b0;
    repeat (gap) @(posedge clk);
    resp_sent <= 1'b1;
    @(posedge clk);
    resp_sent <= 1'b0;
  endtask : transact
endmodule : mcs_host_model
`default_nettype wire

// ===== mcs_top_tb_top.sv
// Purpose: Self-checking bench for the configuration and status block
// Assumes: Module watchdog limit shortened to 50 cycles
// Notes:   Stored settings change once after the first reset, switch varied per reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module mcs_top_tb_top
  import mcs_pkg::*;
;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, recovery_sw = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, smp_pos = 0, reg_rdata;
  logic cfg_chg_req = 0, proto_chg_req = 0, mod_kick = 0;
  logic hwdt_expire = 0, smp_valid = 0, smp_under = 0;
  logic [2:0] smp_chan = 0;
  logic [7:0] nv_addr = 8'h5a;
  logic [5:0] nv_baud = 6'h0a;
  logic nv_cksum = 1'b1, nv_proto = 1'b1;
  logic reg_rvalid, reg_err, led_on, recovery_mode, eff_cksum, eff_proto;
  logic [7:0] eff_addr, rpt_addr;
  logic [5:0] eff_baud, rpt_baud;
  logic rpt_cksum, rpt_proto, chg_ack, chg_grant, mod_reset_req;
  logic safe_state, fast_mode, eng_valid, cmd_received, resp_sent;
  logic signed [15:0] eng_value;
  int n_mismatch = 0, n_tests = 0, cyc = 0, k;
  logic [7:0] codes [9] = '{TC_4_20MA, TC_PM10V, TC_PM5V, TC_PM1V,
    TC_PM500MV, TC_PM150MV, TC_PM20MA, TC_0_20MA, TC_4_20MA_B};
  logic [15:0] mins [9] = '{16'h0fa0, 16'hd8f0, 16'hec78, 16'hd8f0,
    16'hec78, 16'hc568, 16'hb1e0, 16'h0000, 16'h0fa0};
  always #20 clk = ~clk;
  mcs_top #(.MWDT_LIMIT(50)) i_mcs_top (.clk(clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_err(reg_err), .cmd_received(cmd_received), .resp_sent(resp_sent),
    .led_on(led_on), .recovery_sw(recovery_sw), .nv_addr(nv_addr),
    .nv_baud(nv_baud), .nv_cksum(nv_cksum), .nv_proto(nv_proto),
    .recovery_mode(recovery_mode), .eff_addr(eff_addr),
    .eff_baud(eff_baud), .eff_cksum(eff_cksum), .eff_proto(eff_proto),
    .rpt_addr(rpt_addr), .rpt_baud(rpt_baud), .rpt_cksum(rpt_cksum),
    .rpt_proto(rpt_proto), .cfg_chg_req(cfg_chg_req),
    .proto_chg_req(proto_chg_req), .chg_ack(chg_ack),
    .chg_grant(chg_grant), .mod_kick(mod_kick),
    .mod_reset_req(mod_reset_req), .hwdt_expire(hwdt_expire),
    .safe_state(safe_state), .fast_mode(fast_mode),
    .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_pos(smp_pos),
    .smp_under(smp_under), .eng_valid(eng_valid), .eng_value(eng_value));
  mcs_host_model i_mcs_host_model (.clk(clk),
    .cmd_received(cmd_received), .resp_sent(resp_sent));
  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic do_reset(input logic sw);
    @(posedge clk);
    recovery_sw <= sw;
    rst_b       <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [15:0] e,
                     input logic err);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rvalid", 1'b1, reg_rvalid)
    `CHK("reg_err", err, reg_err)
    if (!err) `CHK("reg_rdata", e, reg_rdata)
  endtask : rdc
  task automatic smp(input logic [2:0] c, input logic [15:0] p,
                     input logic u, input logic [15:0] e);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_chan  <= c;
    smp_pos   <= p;
    smp_under <= u;
    @(posedge clk);
    smp_valid <= 1'b0;
    #1;
    `CHK("eng_valid", 1'b1, eng_valid)
    `CHK("eng_value", e, eng_value)
  endtask : smp
  task automatic chg(input logic p, input logic g);
    @(posedge clk);
    cfg_chg_req   <= !p;
    proto_chg_req <= p;
    @(posedge clk);
    cfg_chg_req   <= 1'b0;
    proto_chg_req <= 1'b0;
    #1;
    `CHK("chg_grant", {1'b1, g}, {chg_ack, chg_grant})
  endtask : chg
  task automatic expire;
    @(posedge clk);
    hwdt_expire <= 1'b1;
    @(posedge clk);
    hwdt_expire <= 1'b0;
  endtask : expire
  initial begin
    do_reset(1'b0);
    `CHK("eff", {8'h5a, 6'h0a, 2'b11}, {eff_addr, eff_baud, eff_cksum, eff_proto})
    @(posedge clk);
    {nv_addr, nv_baud, nv_cksum, nv_proto} <= {8'h21, 6'h03, 2'b10};
    repeat (2) @(posedge clk);
    #1;
    `CHK("eff", {8'h21, 6'h03, 2'b10}, {eff_addr, eff_baud, eff_cksum, eff_proto})
    chg(1'b0, 1'b0);
    rdc(ADDR_FIRST_READ, 16'h0001, 1'b0);
    wr(ADDR_FIRST_READ, 16'h0001);
    rdc(ADDR_FIRST_READ, 16'h0000, 1'b0);
    rdc(ADDR_FAST_MODE, 16'h0000, 1'b0);
    wr(ADDR_FAST_MODE, 16'h0001);
    rdc(ADDR_FAST_MODE, 16'h0001, 1'b0);
    `CHK("fast_mode", 1'b1, fast_mode)
    wr(ADDR_FAST_MODE, 16'h0000);
    rdc(ADDR_FAST_MODE, 16'h0000, 1'b0);
    rdc(16'h0100, 16'h0000, 1'b1);
    for (k = 0; k < 8; k++) wr(ADDR_TYPE_BASE + 16'(k), {8'h00, codes[k]});
    for (k = 0; k < 8; k++) rdc(ADDR_TYPE_BASE + 16'(k), {8'h00, codes[k]}, 1'b0);
    smp(3'd1, 16'hffff, 1'b0, 16'h270f);
    smp(3'd0, 16'h0000, 1'b1, 16'h8000);
    smp(3'd7, 16'h0000, 1'b1, 16'h8000);
    wr(ADDR_TYPE_BASE + 16'h0001, {8'h00, TC_4_20MA_B});
    rdc(ADDR_TYPE_BASE + 16'h0001, {8'h00, TC_4_20MA_B}, 1'b0);
    smp(3'd1, 16'h0000, 1'b1, 16'h0000);
    for (k = 0; k < 9; k++) begin
      wr(ADDR_TYPE_LAST, {8'h00, codes[k]});
      smp(3'd7, 16'h0000, 1'b0, mins[k]);
    end
    fork
      i_mcs_host_model.transact(5);
      begin
        repeat (3) @(posedge clk);
        #1;
        `CHK("led_on", 1'b0, led_on)
      end
    join
    #1;
    `CHK("led_on", 1'b1, led_on)
    expire();
    expire();
    #1;
    `CHK("safe_state", 1'b1, safe_state)
    rdc(ADDR_HWDT_STATUS, 16'h0001, 1'b0);
    rdc(ADDR_HWDT_COUNT, 16'h0002, 1'b0);
    wr(ADDR_HWDT_STATUS, 16'h0001);
    rdc(ADDR_HWDT_STATUS, 16'h0000, 1'b0);
    `CHK("safe_state", 1'b0, safe_state)
    wr(ADDR_HWDT_COUNT, 16'h0000);
    rdc(ADDR_HWDT_COUNT, 16'h0000, 1'b0);
    @(posedge clk);
    mod_kick <= 1'b1;
    @(posedge clk);
    mod_kick <= 1'b0;
    #1;
    for (k = 1; k < 70 && !mod_reset_req; k++) @(posedge clk) #1;
    `CHK("mwdt_gap", 1'b1, k >= 45 && k <= 55)
    do_reset(1'b1);
    `CHK("recovery_mode", 1'b1, recovery_mode)
    `CHK("eff", {8'h00, 6'h06, 2'b00}, {eff_addr, eff_baud, eff_cksum, eff_proto})
    `CHK("rpt", {8'h21, 6'h03, 2'b10}, {rpt_addr, rpt_baud, rpt_cksum, rpt_proto})
    chg(1'b1, 1'b1);
    chg(1'b0, 1'b1);
    finish_test();
  end
endmodule : mcs_top_tb_top
`default_nettype wire
